// ---- verilog/cmcs_pkg.sv ----
package cmcs_pkg;
   localparam int WORD_BITS  = 24;
   localparam int ADDR_BITS  = 12;
   localparam int LINE_BITS  = 6;
   localparam int LINE_COUNT = 64;
   localparam int X_LSB      = 0;
   localparam int Y_LSB      = 6;
   localparam int CLK_MHZ    = 100;
   localparam int STEP_NS    = 2000;
   localparam int STEP_CYC   = (STEP_NS * CLK_MHZ + 999) / 1000;
   localparam int STEP_CW    = 8;
   localparam logic [STEP_CW-1:0] STEP_LAST = 8'(STEP_CYC - 1);

   typedef enum logic [2:0] {
      CMCS_IDLE    = 3'b000,
      CMCS_CLEAR   = 3'b001,
      CMCS_WRITE   = 3'b010,
      CMCS_DISTURB = 3'b011
   } cmcs_state_t;
endpackage

// ---- verilog/cmcs_core_storage_system.sv ----
`timescale 1ns/1ps
module cmcs_core_storage_system (
   input  wire logic                               CLK_SYS,
   input  wire logic                               RST_N,
   input  wire logic                               START,
   input  wire logic                               WRITE_MODE,
   input  wire logic [cmcs_pkg::ADDR_BITS-1:0]     ADDR,
   input  wire logic [cmcs_pkg::WORD_BITS-1:0]     WRITE_DATA,
   input  wire logic [cmcs_pkg::WORD_BITS-1:0]     KEEP_MASK,
   input  wire logic [cmcs_pkg::WORD_BITS-1:0]     SENSE,
   output logic                                    BUSY,
   output logic [cmcs_pkg::WORD_BITS-1:0]          WORD_BUF,
   output logic [cmcs_pkg::LINE_COUNT-1:0]         X_DRIVE,
   output logic [cmcs_pkg::LINE_COUNT-1:0]         Y_DRIVE,
   output logic                                    CLEAR_READ,
   output logic                                    WRITE_RESTORE,
   output logic [cmcs_pkg::WORD_BITS-1:0]          INHIBIT,
   output logic                                    READ_PROBE
);
   cmcs_pkg::cmcs_state_t                 state_reg, state_next;
   logic [cmcs_pkg::STEP_CW-1:0]          cnt_reg, cnt_next;
   logic                                  wr_reg;
   logic [cmcs_pkg::ADDR_BITS-1:0]        addr_reg;
   logic [cmcs_pkg::WORD_BITS-1:0]        keep_reg;
   logic [cmcs_pkg::WORD_BITS-1:0]        sense_s1_reg, sense_s2_reg;
   logic [cmcs_pkg::WORD_BITS-1:0]        buf_reg, buf_next;
   logic [cmcs_pkg::LINE_COUNT-1:0]       x_dec, y_dec;
   logic [cmcs_pkg::WORD_BITS-1:0]        inh_next, probe_mask;
   logic                                  step_done, in_clear, in_write, in_dist;
   logic                                  probe_on;
   logic                                  take, nx_write, nx_dist;
   logic [cmcs_pkg::ADDR_BITS-1:0]        addr_sel;

   assign step_done = (cnt_reg == cmcs_pkg::STEP_LAST);
   assign in_clear  = (state_reg == cmcs_pkg::CMCS_CLEAR);
   assign in_write  = (state_reg == cmcs_pkg::CMCS_WRITE);
   assign in_dist   = (state_reg == cmcs_pkg::CMCS_DISTURB);
   assign take      = (state_reg == cmcs_pkg::CMCS_IDLE) && START;
   // next-step decodes keep registered pulses in line with the state
   assign nx_write  = (state_next == cmcs_pkg::CMCS_WRITE);
   assign nx_dist   = (state_next == cmcs_pkg::CMCS_DISTURB);

   // one-hot line select; the new address is used on the taking edge
   // so the first clear pulse never lands on the previous word
   assign addr_sel = take ? ADDR : addr_reg;
   assign x_dec = cmcs_pkg::LINE_COUNT'(1) <<
                  addr_sel[cmcs_pkg::X_LSB +: cmcs_pkg::LINE_BITS];
   assign y_dec = cmcs_pkg::LINE_COUNT'(1) <<
                  addr_sel[cmcs_pkg::Y_LSB +: cmcs_pkg::LINE_BITS];

   // probe only from count 99 to the end of the read step (its last 101 cycles), after the pulse settles
   assign probe_on   = in_clear && (cnt_reg >= (cmcs_pkg::STEP_LAST >> 1));
   // write: only bits kept from the old word are captured; read: all bits
   assign probe_mask = wr_reg ? keep_reg : '1;

   // buffer stage i only ever sees plane i's sense line
   genvar gi;
   generate
      for (gi = 0; gi < cmcs_pkg::WORD_BITS; gi++) begin : g_plane
         always_comb begin
            buf_next[gi] = buf_reg[gi];
            if (take) begin
               // kept bits come only from the probe, never from new data
               buf_next[gi] = WRITE_MODE ? (WRITE_DATA[gi] && !KEEP_MASK[gi]) : 1'b0;
            end else if (probe_on && probe_mask[gi] && sense_s2_reg[gi]) begin
               buf_next[gi] = 1'b1;
            end
            // inhibit follows the coming step so it spans the whole write pulse
            inh_next[gi] = (nx_write && !buf_next[gi]) || nx_dist;
         end
      end
   endgenerate

   always_comb begin
      state_next = state_reg;
      cnt_next   = step_done ? '0 : cnt_reg + 1'b1;
      case (state_reg)
         cmcs_pkg::CMCS_IDLE: begin
            cnt_next = '0;
            if (START) state_next = cmcs_pkg::CMCS_CLEAR;
         end
         cmcs_pkg::CMCS_CLEAR: begin
            if (step_done) state_next = cmcs_pkg::CMCS_WRITE;
         end
         cmcs_pkg::CMCS_WRITE: begin
            if (step_done) state_next = cmcs_pkg::CMCS_DISTURB;
         end
         cmcs_pkg::CMCS_DISTURB: begin
            if (step_done) state_next = cmcs_pkg::CMCS_IDLE;
         end
         default: state_next = cmcs_pkg::CMCS_IDLE;
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         sense_s1_reg <= '0;
         sense_s2_reg <= '0;
      end else begin
         sense_s1_reg <= SENSE;
         sense_s2_reg <= sense_s1_reg;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         state_reg <= cmcs_pkg::CMCS_IDLE;
         cnt_reg   <= '0;
         buf_reg   <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         buf_reg   <= buf_next;
      end
   end

   // address and mode latched at initiation; requester may change them while busy
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         wr_reg   <= 1'b0;
         addr_reg <= '0;
         keep_reg <= '0;
      end else if (take) begin
         wr_reg   <= WRITE_MODE;
         addr_reg <= ADDR;
         keep_reg <= WRITE_MODE ? KEEP_MASK : '0;
      end
   end

   // pulse outputs registered so they are glitch-free toward the drivers
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         X_DRIVE       <= '0;
         Y_DRIVE       <= '0;
         CLEAR_READ    <= 1'b0;
         WRITE_RESTORE <= 1'b0;
         INHIBIT       <= '0;
         READ_PROBE    <= 1'b0;
      end else begin
         X_DRIVE       <= (state_next == cmcs_pkg::CMCS_CLEAR ||
                           state_next == cmcs_pkg::CMCS_WRITE) ? x_dec : '0;
         Y_DRIVE       <= (state_next == cmcs_pkg::CMCS_CLEAR ||
                           state_next == cmcs_pkg::CMCS_WRITE) ? y_dec : '0;
         CLEAR_READ    <= (state_next == cmcs_pkg::CMCS_CLEAR);
         WRITE_RESTORE <= (state_next == cmcs_pkg::CMCS_WRITE);
         INHIBIT       <= inh_next;
         READ_PROBE    <= probe_on;
      end
   end

   assign BUSY     = (state_reg != cmcs_pkg::CMCS_IDLE);
   assign WORD_BUF = buf_reg;

   // ---------------- assertions ----------------
   sequence s_clear_step;
      CLEAR_READ && !WRITE_RESTORE;
   endsequence
   sequence s_restore_step;
      WRITE_RESTORE && !CLEAR_READ;
   endsequence

   step_order_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      $fell(CLEAR_READ) |-> s_restore_step)
      else $error("clear not followed by write step");
   read_restore_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (in_clear && step_done) |=> (in_write && cnt_reg == 0))
      else $error("restore does not follow read");
   clear_pair_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      s_clear_step |-> ($onehot(X_DRIVE) && $onehot(Y_DRIVE)))
      else $error("clear pulse without line pair");
   one_line_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      $onehot0(X_DRIVE) && $onehot0(Y_DRIVE) && ((X_DRIVE == '0) == (Y_DRIVE == '0)))
      else $error("line selection not one of each");
   inhibit_zero_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      in_write |-> (INHIBIT == ~buf_reg))
      else $error("inhibit does not match zero bits");
   disturb_all_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      in_dist |-> (INHIBIT == '1))
      else $error("disturb missing on some plane");
   probe_set_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (probe_on && !wr_reg && sense_s2_reg[0]) |=> WORD_BUF[0])
      else $error("sensed one not captured");
   write_ignore_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (in_clear && wr_reg && keep_reg == '0) |=> $stable(WORD_BUF))
      else $error("write clear sense altered buffer");
   busy_span_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (!BUSY && START) |=> BUSY [*3])
      else $error("busy dropped early");
   addr_decode_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CLEAR_READ |-> (X_DRIVE[addr_reg[5:0]] && Y_DRIVE[addr_reg[11:6]]))
      else $error("wrong line decoded");

   // no drive while idle; word buffer changes only on initiation or through the probe
   idle_quiet_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      !BUSY |-> (INHIBIT == '0 && X_DRIVE == '0 && !CLEAR_READ && !WRITE_RESTORE))
      else $error("drive active while idle");
   read_capture_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (probe_on && !wr_reg) |=> ((WORD_BUF & $past(sense_s2_reg)) == $past(sense_s2_reg)))
      else $error("sensed ones not all captured");
   replace_drop_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (probe_on && wr_reg && !keep_reg[0]) |=> $stable(WORD_BUF[0]))
      else $error("replaced bit captured old value");
   sense_ignore_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (!take && !probe_on) |=> $stable(WORD_BUF))
      else $error("buffer changed outside probe");
endmodule

// ---- tb/cmcs_plane_model.sv ----
`timescale 1ns/1ps
module cmcs_plane_model (
   input  wire logic                            clk_sys,
   input  wire logic [cmcs_pkg::LINE_COUNT-1:0] x_drive,
   input  wire logic [cmcs_pkg::LINE_COUNT-1:0] y_drive,
   input  wire logic                            clear_read,
   input  wire logic                            write_restore,
   input  wire logic [cmcs_pkg::WORD_BITS-1:0]  inhibit,
   output logic      [cmcs_pkg::WORD_BITS-1:0]  sense
);
   logic [cmcs_pkg::WORD_BITS-1:0] core_mem [4096];
   logic [11:0]                    sel;
   logic                           both;
   always_comb begin
      sel = 12'h000;
      for (int i = 0; i < 64; i++) begin
         if (x_drive[i]) sel[5:0] = 6'(i);
         if (y_drive[i]) sel[11:6] = 6'(i);
      end
   end
   initial begin
      foreach (core_mem[i]) core_mem[i] = 24'h000000;
   end
   // half-selected cores never switch, so only the crossing is touched
   assign both = |x_drive && |y_drive;
   // sense also pulses on write clear; the sequencer captures only the kept bits from it
   assign sense = (clear_read && both) ? core_mem[sel] : 24'h000000;
   always @(posedge clk_sys) begin
      if (write_restore && both) begin
         core_mem[sel] <= ~inhibit;
      end
   end
endmodule

// ---- tb/tb_cmcs_core_storage_system.sv ----
`timescale 1ns/1ps
module tb_cmcs_core_storage_system;
   typedef struct packed {
      logic wr; logic [11:0] addr; logic [23:0] data; logic [23:0] keep; logic [23:0] exp;
   } cmcs_row_t;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic        start = 1'b0;
   logic        write_mode = 1'b0;
   logic [11:0] addr = 12'h000;
   logic [23:0] write_data = 24'h000000;
   logic [23:0] keep_mask = 24'h000000;
   logic [23:0] sense, word_buf, inhibit;
   logic [63:0] x_drive, y_drive;
   logic        busy, clear_read, write_restore, read_probe;
   int          errors = 0;
   int          n_checks = 0;
   int          cyc = 0;
   cmcs_row_t   rows [9] = '{
      '{1'b1, 12'h000, 24'habcdef, 24'h000000, 24'habcdef},
      '{1'b1, 12'hfff, 24'h123456, 24'h000000, 24'h123456},
      '{1'b0, 12'h000, 24'h000000, 24'h000000, 24'habcdef},
      '{1'b0, 12'h000, 24'h000000, 24'h000000, 24'habcdef},
      '{1'b0, 12'hfff, 24'h000000, 24'h000000, 24'h123456},
      '{1'b1, 12'h000, 24'hff00ff, 24'h00ffff, 24'hffcdef},
      '{1'b1, 12'h000, 24'h550000, 24'h000000, 24'h550000},
      '{1'b0, 12'h000, 24'h000000, 24'h000000, 24'h550000},
      '{1'b0, 12'h040, 24'h000000, 24'h000000, 24'h000000}};
   always #5 clk_sys = ~clk_sys;
   cmcs_core_storage_system i_cmcs_core_storage_system (.CLK_SYS(clk_sys), .RST_N(rst_n),
      .START(start), .WRITE_MODE(write_mode), .ADDR(addr), .WRITE_DATA(write_data),
      .KEEP_MASK(keep_mask), .SENSE(sense), .BUSY(busy), .WORD_BUF(word_buf),
      .X_DRIVE(x_drive), .Y_DRIVE(y_drive), .CLEAR_READ(clear_read),
      .WRITE_RESTORE(write_restore), .INHIBIT(inhibit), .READ_PROBE(read_probe));
   cmcs_plane_model i_cmcs_plane_model (.clk_sys(clk_sys), .x_drive(x_drive),
      .y_drive(y_drive), .clear_read(clear_read), .write_restore(write_restore),
      .inhibit(inhibit), .sense(sense));
   task chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task finish_test;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic pulse_start(input cmcs_row_t r);
      write_mode = r.wr;
      addr = r.addr;
      write_data = r.data;
      keep_mask = r.keep;
      start = 1'b1;
      @(negedge clk_sys);
      start = 1'b0;
   endtask
   task automatic wait_idle;
      for (int w = 0; w < 700 && busy !== 1'b0; w++) @(negedge clk_sys);
   endtask
   task automatic run_cycle(input cmcs_row_t r);
      pulse_start(r);
      chk("busy", 64'(busy), 64'h1);
      chk("clear_read", 64'(clear_read), 64'h1);
      chk("x_drive", x_drive, 64'h1 << r.addr[5:0]);
      chk("y_drive", y_drive, 64'h1 << r.addr[11:6]);
      chk("inhibit_clr", 64'(inhibit), 64'h0);
      chk("probe_early", 64'(read_probe), 64'h0);
      repeat (149) @(negedge clk_sys);
      chk("probe_late", 64'(read_probe), 64'h1);
      repeat (51) @(negedge clk_sys);
      chk("write_restore", 64'(write_restore), 64'h1);
      chk("x_drive_wr", x_drive, 64'h1 << r.addr[5:0]);
      chk("inhibit_wr", 64'(inhibit), {40'h0, ~r.exp});
      repeat (200) @(negedge clk_sys);
      chk("inhibit_dist", 64'(inhibit), 64'hffffff);
      chk("x_drive_dist", x_drive, 64'h0);
      wait_idle();
      chk("busy_end", 64'(busy), 64'h0);
      chk("inhibit_idle", 64'(inhibit), 64'h0);
      chk("word_buf", 64'(word_buf), 64'(r.exp));
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         finish_test();
      end
   end
   initial begin
      repeat (4) @(negedge clk_sys);
      rst_n = 1'b1;
      foreach (rows[i]) begin
         run_cycle(rows[i]);
         $display("row %0d done", i);
      end
      // a write request inside a read must leave no trace
      pulse_start(rows[7]);
      repeat (100) @(negedge clk_sys);
      pulse_start('{1'b1, 12'hfff, 24'h000000, 24'h000000, 24'h000000});
      wait_idle();
      chk("word_buf_refused", 64'(word_buf), 64'h550000);
      run_cycle(rows[4]);
      $display("refused start test done");
      pulse_start(rows[0]);
      repeat (50) @(negedge clk_sys);
      rst_n = 1'b0;
      @(negedge clk_sys);
      chk("busy_rst", 64'(busy), 64'h0);
      chk("x_drive_rst", x_drive, 64'h0);
      rst_n = 1'b1;
      run_cycle(rows[8]);
      $display("reset test done");
      finish_test();
   end
endmodule
